/* logic/adci_i2c_port.sv */
// Purpose: two-wire target control port of a stereo audio dac
// Assumes: pins asynchronous to CLK; SCL well below CLK/20
// Notes:   sda is open drain, only ever pulled low
// Operation
// - target only; master frames every transfer
// - control pins become address bits, SCL, SDA
// - address upper five bits fixed 10011
// - two low address bits from pins; match only
// - index increments after each written byte
// - index wraps from 0x7F to zero
// - no acknowledge for undefined register writes
// - index set by write, then read returns it
// - index increments after each transmitted byte
// - first read after write not pre-incremented
// - indices 0x10..0x1F always return a byte
// - lines filtered by sampling with system clock
// - slow clock short start hold misses start
// - fast clock long spikes may fake start/stop
// - left and right attenuation registers, 0 dB default
// - attenuation load bit gates new codes, off
// - three-bit format field, 24-bit i2s default
// - two-bit de-emphasis rate field, disabled default
// - de-emphasis enable bit, disabled default
// - soft mute bit, disabled default
// - two-wire mode only when select strap high
// - attenuation registers reset to all ones
`timescale 1ns/100ps
module adci_i2c_port
  import adci_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       INTERFACE_SELECT,
  input  wire logic       CTRL_SELECT_N,
  input  wire logic       CTRL_SERIAL_IN,
  input  wire logic       CTRL_SERIAL_CLOCK,
  input  wire logic       CTRL_SERIAL_OUT_I,
  output logic            CTRL_SERIAL_OUT_O,
  output logic            CTRL_SERIAL_OUT_OE,
  output logic      [7:0] LEFT_ATTEN_LEVEL,
  output logic      [7:0] RIGHT_ATTEN_LEVEL,
  output logic            ATTEN_LOAD_ENABLE,
  output logic      [2:0] INPUT_FORMAT_SEL,
  output logic      [1:0] DEEMPH_RATE_SEL,
  output logic            DEEMPH_ENABLE,
  output logic            SOFT_MUTE
);

  typedef struct packed {
    logic [4:0]       meta;
    logic [4:0]       sync;
    logic [1:0]       filt;
    logic [1:0][3:0]  fcnt;
    adci_state_t      st;
    logic [3:0]       bcnt;
    logic [7:0]       shr;
    logic             rw;
    logic             macked;
    logic [6:0]       idx;
    logic             oe;
    logic             wr;
    logic [6:0]       waddr;
    logic [7:0]       wdat;
    logic [7:0]       atl;
    logic [7:0]       atr;
  } adci_port_t;

  adci_port_t q;
  adci_port_t d;

  logic [7:0] rd_data;
  logic [7:0] left_q;
  logic [7:0] right_q;
  logic [7:0] ctrl_q;
  logic       scl_r;
  logic       scl_f;
  logic       start_c;
  logic       stop_c;
  logic       mode;
  logic       addr_ok;

  adci_regfile u_regs (
    .clk     (CLK),
    .nrst    (NRST),
    .wr_en   (q.wr),
    .wr_addr (q.waddr),
    .wr_data (q.wdat),
    .rd_addr (q.idx),
    .rd_data (rd_data),
    .left_q  (left_q),
    .right_q (right_q),
    .ctrl_q  (ctrl_q)
  );

  always_comb begin
    d = q;
    d.wr = 1'b0;
    // pins are repurposed only in two-wire mode
    d.meta = {CTRL_SERIAL_OUT_I, CTRL_SERIAL_CLOCK, CTRL_SERIAL_IN,
              CTRL_SELECT_N, INTERFACE_SELECT};
    d.sync = q.meta;
    // a line must hold its new level FILT_CYC cycles to be taken;
    // shorter spikes vanish, longer ones pass as real edges
    for (int i = 0; i < 2; i++) begin
      if (q.sync[PIN_SCL + i] == q.filt[i]) begin
        d.fcnt[i] = 4'h0;
      end else if (q.fcnt[i] == FILT_CNT_MAX) begin
        d.filt[i] = q.sync[PIN_SCL + i];
        d.fcnt[i] = 4'h0;
      end else begin
        d.fcnt[i] = q.fcnt[i] + 4'h1;
      end
    end
    scl_r   = d.filt[0] & ~q.filt[0];
    scl_f   = ~d.filt[0] & q.filt[0];
    start_c = q.filt[0] & d.filt[0] & q.filt[1] & ~d.filt[1];
    stop_c  = q.filt[0] & d.filt[0] & ~q.filt[1] & d.filt[1];
    mode    = q.sync[PIN_SEL];
    addr_ok = q.shr[7:1] == {DEV_ADDR_HI, q.sync[PIN_A1],
                             q.sync[PIN_A0]};
    if (!mode || stop_c) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end else if (start_c) begin
      d.st   = ST_ADDR;
      d.bcnt = 4'h0;
      d.oe   = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE, ST_IGNORE: begin
          d.oe = 1'b0;
        end
        ST_ADDR, ST_IDX, ST_WDATA: begin
          if (scl_r) begin
            d.shr  = {q.shr[6:0], d.filt[1]};
            d.bcnt = q.bcnt + 4'h1;
          end else if (scl_f && q.bcnt == BITS_BYTE) begin
            d.bcnt = 4'h0;
            if (q.st == ST_ADDR) begin
              if (addr_ok) begin
                d.oe = 1'b1;
                d.rw = q.shr[0];
                d.st = ST_ADDR_ACK;
              end else begin
                d.st = ST_IGNORE;
              end
            end else if (q.st == ST_IDX) begin
              d.idx = q.shr[6:0];
              d.oe  = 1'b1;
              d.st  = ST_IDX_ACK;
            end else if (adci_defined(q.idx)) begin
              d.oe    = 1'b1;
              d.wr    = 1'b1;
              d.waddr = q.idx;
              d.wdat  = q.shr;
              d.idx   = q.idx + IDX_STEP;
              d.st    = ST_WDATA_ACK;
            end else begin
              d.st = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK, ST_IDX_ACK, ST_WDATA_ACK: begin
          if (scl_f) begin
            d.oe   = 1'b0;
            d.bcnt = 4'h0;
            if (q.st == ST_ADDR_ACK && q.rw) begin
              // index untouched here, so a read starts where set
              d.st  = ST_RDATA;
              d.shr = rd_data;
              d.oe  = ~rd_data[7];
            end else if (q.st == ST_ADDR_ACK) begin
              d.st = ST_IDX;
            end else begin
              d.st = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_r) begin
            d.bcnt = q.bcnt + 4'h1;
          end else if (scl_f) begin
            if (q.bcnt == BITS_BYTE) begin
              d.oe  = 1'b0;
              d.idx = q.idx + IDX_STEP;
              d.st  = ST_RDATA_ACK;
            end else begin
              d.shr = {q.shr[6:0], 1'b0};
              d.oe  = ~q.shr[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_r) begin
            d.macked = ~d.filt[1];
          end else if (scl_f) begin
            d.bcnt = 4'h0;
            if (q.macked) begin
              d.st  = ST_RDATA;
              d.shr = rd_data;
              d.oe  = ~rd_data[7];
            end else begin
              d.st = ST_IGNORE;
            end
          end
        end
      endcase
    end
    // new codes reach the datapath only while loading is on
    if (ctrl_q[ATTEN_LOAD_ENABLE_BIT]) begin
      d.atl = left_q;
      d.atr = right_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      q        <= '0;
      q.meta   <= 5'h1e;
      q.sync   <= 5'h1e;
      q.filt   <= 2'h3;
      q.st     <= ST_IDLE;
      q.atl    <= ATTEN_RESET;
      q.atr    <= ATTEN_RESET;
    end else begin
      q <= d;
    end
  end

  // open drain: the data level is always low, the enable pulls
  assign CTRL_SERIAL_OUT_O  = 1'b0;
  assign CTRL_SERIAL_OUT_OE = q.oe;
  assign LEFT_ATTEN_LEVEL   = q.atl;
  assign RIGHT_ATTEN_LEVEL  = q.atr;
  assign ATTEN_LOAD_ENABLE  = ctrl_q[ATTEN_LOAD_ENABLE_BIT];
  assign INPUT_FORMAT_SEL   = ctrl_q[FMT_LSB +: 3];
  assign DEEMPH_RATE_SEL    = ctrl_q[DMF_LSB +: 2];
  assign DEEMPH_ENABLE      = ctrl_q[DME_BIT];
  assign SOFT_MUTE          = ctrl_q[MUTE_BIT];

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  AST_MODE_OFF_RELEASE: assert property (
    !mode |=> !CTRL_SERIAL_OUT_OE)
    else $error("sda driven outside two-wire mode");

  AST_IDLE_RELEASE: assert property (
    (q.st == ST_IDLE || q.st == ST_IGNORE) |-> !CTRL_SERIAL_OUT_OE)
    else $error("sda driven while not addressed");

  AST_ADDR_MATCH_ACK: assert property (
    (q.st == ST_ADDR && scl_f && q.bcnt == BITS_BYTE && addr_ok
     && mode && !stop_c && !start_c)
    |=> CTRL_SERIAL_OUT_OE && q.st == ST_ADDR_ACK)
    else $error("own address not acknowledged");

  AST_ADDR_MISS: assert property (
    (q.st == ST_ADDR && scl_f && q.bcnt == BITS_BYTE && !addr_ok)
    |=> !CTRL_SERIAL_OUT_OE)
    else $error("foreign address acknowledged");

  AST_WR_INC: assert property (
    q.wr |-> q.idx == 7'(q.waddr + IDX_STEP))
    else $error("index not advanced after write");

  AST_IDX_WRAP: assert property (
    (q.st == ST_RDATA && d.st == ST_RDATA_ACK && q.idx == 7'h7f)
    |=> q.idx == 7'h00)
    else $error("index did not wrap");

  AST_UNDEF_NACK: assert property (
    (q.st == ST_WDATA && scl_f && q.bcnt == BITS_BYTE
     && !adci_defined(q.idx)) |=> !CTRL_SERIAL_OUT_OE && !q.wr)
    else $error("undefined register acknowledged");

  AST_RD_INC: assert property (
    (q.st == ST_RDATA && d.st == ST_RDATA_ACK)
    |=> q.idx == 7'($past(q.idx) + IDX_STEP))
    else $error("read index not advanced");

  AST_RD_ACK_FREE: assert property (
    q.st == ST_RDATA_ACK |-> !CTRL_SERIAL_OUT_OE)
    else $error("sda held in master ack slot");

  AST_FILTER_HOLD: assert property (
    $changed(q.filt) |-> $past(q.fcnt[0]) == FILT_CNT_MAX
                         || $past(q.fcnt[1]) == FILT_CNT_MAX)
    else $error("line change passed the filter early");

  AST_LOAD_GATE: assert property (
    !ATTEN_LOAD_ENABLE |=> $stable(LEFT_ATTEN_LEVEL))
    else $error("attenuation moved while load off");

  COV_WRITE: cover property (q.wr ##[1:600] q.wr);
  COV_READ_BURST: cover property (
    q.st == ST_RDATA_ACK && scl_f && q.macked);
  COV_FOREIGN: cover property (
    q.st == ST_ADDR && d.st == ST_IGNORE);

endmodule

/* logic/adci_pkg.sv */
// Purpose: shared constants and types of the dac two-wire control port
// Assumes: 200 MHz system clock
// Notes:   register indices double as the wire-level register address
package adci_pkg;

  // fixed upper part of the 7-bit target address
  localparam logic [4:0] DEV_ADDR_HI = 5'h13;

  // register indices
  localparam logic [6:0] REG_LEFT    = 7'h10;
  localparam logic [6:0] REG_RIGHT   = 7'h11;
  localparam logic [6:0] REG_CTRL    = 7'h12;
  localparam logic [6:0] RD_WIN_LO   = 7'h10;
  localparam logic [6:0] RD_WIN_HI   = 7'h1f;
  localparam logic [6:0] IDX_STEP    = 7'h01;

  // control register field positions
  localparam int ATTEN_LOAD_ENABLE_BIT  = 7;
  localparam int FMT_LSB   = 4;
  localparam int DMF_LSB   = 2;
  localparam int DME_BIT   = 1;
  localparam int MUTE_BIT  = 0;

  // reset values
  localparam logic [7:0] ATTEN_RESET = 8'hff;
  // code chosen for the 24-bit i2s format
  localparam logic [2:0] FMT_RESET   = 3'h4;
  localparam logic [7:0] CTRL_RESET  = {1'b0, FMT_RESET, 4'h0};

  // pin positions inside the synchroniser vectors
  localparam int PIN_SEL = 0;
  localparam int PIN_A0  = 1;
  localparam int PIN_A1  = 2;
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 4;

  // glitch filter: spikes shorter than this width are rejected
  localparam int         CLK_MHZ      = 200;
  localparam int         FILT_NS      = 50;
  localparam int         FILT_CYC     = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] FILT_CNT_MAX = 4'(FILT_CYC - 1);
  localparam logic [3:0] BITS_BYTE    = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_IDX, ST_IDX_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
  } adci_state_t;

  function automatic logic adci_defined(input logic [6:0] idx);
    return (idx >= REG_LEFT) && (idx <= REG_CTRL);
  endfunction

endpackage

/* logic/adci_regfile.sv */
// Purpose: mode control registers with registered read port
// Assumes: write and read index come from the two-wire engine
// Notes:   unmapped indices inside the read window return zero
`timescale 1ns/100ps
module adci_regfile
  import adci_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic      [7:0] left_q,
  output logic      [7:0] right_q,
  output logic      [7:0] ctrl_q
);

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
    logic [7:0] ctrl;
    logic [7:0] rd;
  } adci_rf_t;

  adci_rf_t q;
  adci_rf_t d;

  always_comb begin
    d = q;
    if (wr_en) begin
      unique case (wr_addr)
        REG_LEFT:  d.left  = wr_data;
        REG_RIGHT: d.right = wr_data;
        REG_CTRL:  d.ctrl  = wr_data;
        default:   d.ctrl  = q.ctrl;
      endcase
    end
    d.rd = 8'h00;
    if (rd_addr >= RD_WIN_LO && rd_addr <= RD_WIN_HI) begin
      unique case (rd_addr)
        REG_LEFT:  d.rd = q.left;
        REG_RIGHT: d.rd = q.right;
        REG_CTRL:  d.rd = q.ctrl;
        default:   d.rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '{left: ATTEN_RESET, right: ATTEN_RESET,
             ctrl: CTRL_RESET, rd: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
  assign left_q  = q.left;
  assign right_q = q.right;
  assign ctrl_q  = q.ctrl;

  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!nrst)
    (wr_en && wr_addr == REG_LEFT) |=> left_q == $past(wr_data))
    else $error("left attenuation write lost");

endmodule

/* verification/adci_master.sv */
// Purpose: behavioural two-wire bus master for the dac control port
// Assumes: open-drain sda with pull-up resolved in the bench
// Notes:   125 ns bit, scl low 70 ns and high 55 ns; idle scl stays high
`timescale 1ns/100ps
module adci_master (
  input  wire logic glitch,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // the device answers up to 60 ns after a fall it sees, so sda
  // only moves after that; high phase just clears the 50 ns filter
  localparam real T_SET   = 65.0;
  localparam real T_SU    = 5.0;
  localparam real T_HIGH  = 55.0;
  localparam real T_HOLD  = 60.0;
  localparam real T_SPIKE = 20.0;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // scl rises only once a pending device ack has been released
  task automatic start();
    sda_low = 1'b0;
    #T_SET;
    scl = 1'b1;
    #T_HOLD;
    sda_low = 1'b1;
    #T_HOLD;
    scl = 1'b0;
  endtask

  task automatic stop();
    #T_SET;
    sda_low = 1'b1;
    #T_SU;
    scl = 1'b1;
    #T_HOLD;
    sda_low = 1'b0;
    #T_HOLD;
  endtask

  // sda leads scl so the device's delayed view keeps the order
  task automatic bit_io(input logic b, output logic r);
    if (glitch) begin
      // 20 ns scl spike after the fall is taken, below the filter
      #T_SET;
      scl = 1'b1;
      #T_SPIKE;
      scl = 1'b0;
    end
    #T_SET;
    sda_low = ~b;
    #T_SU;
    scl = 1'b1;
    #T_HIGH;
    r   = sda;
    scl = 1'b0;
  endtask

  // ab is put on the ack slot; 1 releases it
  task automatic xfer(input logic [7:0] tx, input logic ab,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ab, r);
    ack = ~r;
  endtask
endmodule

/* verification/test_adci_i2c_port.sv */
// Purpose: self-checking bench of the dac two-wire control port
// Assumes: master model owns scl and pulls sda; pull-up modelled here
// Notes:   strap and address pins change only between frames
`timescale 1ns/100ps
module test_adci_i2c_port;
  import adci_pkg::*;

  logic       clk;
  logic       nrst;
  logic       if_sel;
  logic       a0;
  logic       a1;
  logic       glitch;
  logic       scl;
  logic       m_low;
  logic       oe;
  logic       o;
  logic [7:0] left;
  logic [7:0] right;
  logic       ld;
  logic [2:0] fmt;
  logic [1:0] rate;
  logic       deemph_enable;
  logic       mute;
  logic [7:0] rx;
  logic       ack;
  int         bad_count;
  int         checks;
  wire        sda = ~(m_low | (oe & ~o));

  adci_i2c_port adci_i2c_port_i (
    .CLK                (clk),
    .NRST               (nrst),
    .INTERFACE_SELECT   (if_sel),
    .CTRL_SELECT_N      (a0),
    .CTRL_SERIAL_IN     (a1),
    .CTRL_SERIAL_CLOCK  (scl),
    .CTRL_SERIAL_OUT_I  (sda),
    .CTRL_SERIAL_OUT_O  (o),
    .CTRL_SERIAL_OUT_OE (oe),
    .LEFT_ATTEN_LEVEL   (left),
    .RIGHT_ATTEN_LEVEL  (right),
    .ATTEN_LOAD_ENABLE  (ld),
    .INPUT_FORMAT_SEL   (fmt),
    .DEEMPH_RATE_SEL    (rate),
    .DEEMPH_ENABLE      (deemph_enable),
    .SOFT_MUTE          (mute)
  );

  adci_master adci_master_i (
    .glitch  (glitch),
    .sda     (sda),
    .scl     (scl),
    .sda_low (m_low)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string w, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", w, exp, got);
    end
  endtask

  function automatic logic [7:0] addr(input logic rd);
    return {DEV_ADDR_HI, a1, a0, rd};
  endfunction

  function automatic logic [7:0] ctl();
    return {ld, fmt, rate, deemph_enable, mute};
  endfunction

  task automatic put(input logic [7:0] b, input logic ea, input string w);
    adci_master_i.xfer(b, 1'b1, rx, ack);
    check(w, {7'h0, ea}, {7'h0, ack});
  endtask

  task automatic get(input logic [7:0] exp, input logic last,
                     input string w);
    adci_master_i.xfer(8'hff, last, rx, ack);
    check(w, exp, rx);
    if (last) begin
      check("ack_slot", 8'h00, {7'h0, ack});
    end
  endtask

  // index is loaded by a write, then a repeated start turns to read
  task automatic point(input logic [6:0] idx);
    adci_master_i.start();
    put(addr(1'b0), 1'b1, "addr_w");
    put({1'b0, idx}, 1'b1, "index");
    adci_master_i.start();
    put(addr(1'b1), 1'b1, "addr_r");
  endtask

  task automatic pins(input logic s, input logic b0, input logic b1);
    @(posedge clk);
    if_sel <= s;
    a0     <= b0;
    a1     <= b1;
    repeat (20) @(posedge clk);
  endtask

  task automatic t_reset();
    check("left_out", ATTEN_RESET, left);
    check("right_out", ATTEN_RESET, right);
    check("ctrl_out", CTRL_RESET, ctl());
    point(REG_LEFT);
    get(ATTEN_RESET, 1'b0, "rd_left");
    get(ATTEN_RESET, 1'b0, "rd_right");
    get(CTRL_RESET, 1'b0, "rd_ctrl");
    get(8'h00, 1'b1, "rd_unmapped");
    adci_master_i.stop();
    point(7'h7f);
    adci_master_i.xfer(8'hff, 1'b0, rx, ack);
    adci_master_i.xfer(8'hff, 1'b1, rx, ack);
    adci_master_i.stop();
    $display("test reset done");
  endtask

  task automatic t_write();
    adci_master_i.start();
    put(addr(1'b0), 1'b1, "addr_w");
    put({1'b0, REG_LEFT}, 1'b1, "index");
    put(8'h5a, 1'b1, "wr_left");
    put(8'h3c, 1'b1, "wr_right");
    check("left_held", ATTEN_RESET, left);
    put(8'h9b, 1'b1, "wr_ctrl");
    put(8'h11, 1'b0, "wr_undef");
    adci_master_i.stop();
    check("left_out", 8'h5a, left);
    check("right_out", 8'h3c, right);
    check("ctrl_out", 8'h9b, ctl());
    point(REG_RIGHT);
    get(8'h3c, 1'b0, "rd_right");
    get(8'h9b, 1'b1, "rd_ctrl");
    adci_master_i.stop();
    $display("test write done");
  endtask

  task automatic t_addr();
    for (int p = 0; p < 4; p++) begin
      pins(1'b1, p[0], p[1]);
      adci_master_i.start();
      put(addr(1'b0) ^ 8'h02, 1'b0, "addr_other");
      put(8'h00, 1'b0, "after_other");
      adci_master_i.start();
      put(addr(1'b0) ^ 8'h80, 1'b0, "addr_top");
      adci_master_i.start();
      put(addr(1'b1), 1'b1, "addr_own");
      get(8'h00, 1'b1, "rd_own");
      adci_master_i.stop();
    end
    $display("test address done");
  endtask

  task automatic t_off();
    pins(1'b0, a0, a1);
    adci_master_i.start();
    put(addr(1'b0), 1'b0, "addr_off");
    adci_master_i.stop();
    pins(1'b1, a0, a1);
    $display("test strap done");
  endtask

  task automatic t_glitch();
    glitch = 1'b1;
    adci_master_i.start();
    put(addr(1'b0), 1'b1, "addr_w");
    put({1'b0, REG_LEFT}, 1'b1, "index");
    put(8'hc3, 1'b1, "wr_left");
    adci_master_i.stop();
    glitch = 1'b0;
    check("left_glitch", 8'hc3, left);
    point(REG_LEFT);
    get(8'hc3, 1'b1, "rd_glitch");
    adci_master_i.stop();
    $display("test glitch done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    checks    = 0;
    nrst      = 1'b0;
    if_sel    = 1'b1;
    a0        = 1'b0;
    a1        = 1'b0;
    glitch    = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    t_reset();
    t_write();
    t_addr();
    t_off();
    t_glitch();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("BAD run expected end seen hang");
    stop_test();
  end
endmodule
